//--- fcm_checker.sv
`timescale 1ns/1ps
// watches the link between the two ends, plus the device status lines
module fcm_checker (
    // clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // link signals
    input wire logic wr_valid,
    input wire logic word_size,
    input wire logic rd_valid,
    input wire logic rd_ok,
    input wire logic ready_busy_flag,
    // device status
    input wire logic lock_out,
    input wire logic erase_out,
    input wire logic array_wr_out
);
    // one domain, so one clocking and one disable for all
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!reset_n_in);

    // commands are only ever full words
    width_only_a: assert property (wr_valid |-> word_size)
        else $error("narrow command write");
    // the host spaces its writes one after another
    write_spacing_a: assert property (wr_valid |=> !wr_valid)
        else $error("write strobe longer than one cycle");
    // a read in a ready mode is answered next cycle
    read_answer_a: assert property (rd_valid && ready_busy_flag |=> rd_ok)
        else $error("read not answered");
    // flag low one cycle on means the mode was busy: no data
    read_refuse_a: assert property ((rd_valid ##1 !ready_busy_flag) |-> !rd_ok)
        else $error("array data during automatic operation");
    // an answer always has a read behind it
    read_cause_a: assert property (rd_ok |-> $past(rd_valid))
        else $error("answer without a read");
    // first cycle out of reset is read mode
    reset_ready_a: assert property ($rose(reset_n_in) |-> ready_busy_flag && !lock_out && !rd_ok)
        else $error("not in read mode after reset");
    // only a hardware reset leaves the locked state
    lock_hold_a: assert property (lock_out |=> lock_out)
        else $error("lock left without reset");
    // locked counts as busy
    lock_busy_a: assert property (lock_out |-> !ready_busy_flag)
        else $error("ready while locked");
    // page words are only taken while busy
    prog_busy_a: assert property (array_wr_out |-> !ready_busy_flag)
        else $error("page write while ready");
    // erase start pulls the flag low within a cycle
    erase_busy_a: assert property ($rose(erase_out) |-> ##[0:1] !ready_busy_flag)
        else $error("erase running while ready");
endmodule

//--- fcm_defs.svh
`ifndef FCM_DEFS_SVH
`define FCM_DEFS_SVH
// bus widths
`define FCM_AW 32
`define FCM_DW 32
// command codes used in the bus write sequences
`define FCM_UNLOCK_A1 32'h0000_5400
`define FCM_UNLOCK_D1 32'h0000_00aa
`define FCM_UNLOCK_A2 32'h0000_aa00
`define FCM_UNLOCK_D2 32'h0000_0055
`define FCM_CMD_A3    32'h0000_5400
`define FCM_READ_DATA 32'h0000_00f0
`define FCM_CMD_PROG  32'h0000_00a0
`define FCM_CMD_IDRD  32'h0000_0090
`define FCM_CMD_ERASE 32'h0000_0080
`define FCM_CMD_CHIP  32'h0000_0010
`define FCM_CMD_BLOCK 32'h0000_0030
// block select field of an array address
`define FCM_BLK_LSB 16
// default operation durations in cycles
`define FCM_PROG_CYC  16'h0100
`define FCM_ERASE_CYC 16'h0400
// words in one page
`define FCM_PAGE_WORDS 8'h80
`define FCM_ZERO8 8'h00
`endif

//--- fcm_device.sv
`timescale 1ns/1ps
`include "fcm_defs.svh"
// What this block does, and what it expects of the host
// - host uses 32-bit writes for commands
// - accepted command runs on its own
// - page program, chip erase, block erase
// - protected blocks are never modified
// - automatic mode only entered from read or identifier read
// - no array data during automatic operation
// - only hardware reset or normal end leaves automatic mode
// - read mode after reset and normal end
// - software or hardware reset recovers read
// - identifier read stays until F0 write or a new sequence
// - single F0 write returns read mode
// - reset sequence ends at third write
// - reset sequence cancels partial command
// - first mismatch aborts to read mode
// - host runs sequences outside array, in order
// - host makes no array access meanwhile
// - host checks ready before first write
// - host issues reset after wrong write; fcm_host does not, the mismatch alone returns read mode
// - cpu reset aborts operation, read mode
// - reset vector readable after reset
// - normal program end sets ready, read
// - new commands ignored during programming
module fcm_device
    import fcm_pkg::*;
#(
    parameter int          BLOCKS    = 8,
    parameter logic [15:0] PROG_CYC  = `FCM_PROG_CYC,
    parameter logic [15:0] ERASE_CYC = `FCM_ERASE_CYC
) (
    // clock and reset
    input  wire logic mclk_in,
    input  wire logic reset_n_in,
    // bus side
    fcm_if.dev        bus,
    // array side
    input  wire logic [BLOCKS-1:0]  protect_in,     // per-block inhibit
    input  wire logic [`FCM_DW-1:0] array_data_in,  // raw array data
    input  wire logic               fail_in,        // array reports failure
    output logic                    array_wr_out,   // one word program pulse
    output logic                    erase_out,      // erase in progress
    output logic [BLOCKS-1:0]       erase_sel_out,  // blocks being erased
    output logic                    lock_out        // abnormal end, held
);
    fcm_mode_t          mode_r;      // controller mode
    fcm_op_t            op_r;        // running operation
    logic [7:0]         words_r;     // page words still expected
    logic               prot_r;      // target block protected
    logic [BLOCKS-1:0]  sel_r;       // erase block set
    logic               tstart_r;    // timer kick
    logic [15:0]        tlen_r;      // timer length
    logic               tbusy;       // timer running
    logic               tdone;       // timer finished
    logic               wr32;        // well-formed write
    logic [BLOCKS-1:0]  blk_hit;     // block decoded from address
    logic               auto_mode;   // any automatic mode
    logic               is_f0;       // single-cycle read command
    initial begin
        if (BLOCKS < 1 || BLOCKS > 32) $error("fcm_device: BLOCKS out of range");
    end
    assign wr32      = bus.wr_valid && bus.word_size;
    assign is_f0     = wr32 && (bus.wdata == `FCM_READ_DATA);
    assign auto_mode = (mode_r == FCM_PAGE) || (mode_r == FCM_BUSY) || (mode_r == FCM_LOCK);

    // one-hot block decode, one entry per block
    genvar g;
    generate
        for (g = 0; g < BLOCKS; g++) begin : g_blk
            assign blk_hit[g] = (bus.addr[`FCM_BLK_LSB +: 5] == 5'(g));
        end
    endgenerate

    fcm_timer #(.CW(16)) u_timer (
        .mclk_in   (mclk_in),
        .reset_n_in(reset_n_in),
        .start_in  (tstart_r),
        .len_in    (tlen_r),
        .busy_out  (tbusy),
        .done_out  (tdone)
    );

    // command recognition and mode, reset forces read mode
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            mode_r   <= FCM_READ;
            op_r     <= FCM_OP_PROG;
            words_r  <= `FCM_ZERO8;
            prot_r   <= 1'b0;
            sel_r    <= '0;
            tstart_r <= 1'b0;
            tlen_r   <= '0;
        end else begin
            tstart_r <= 1'b0;
            unique case (mode_r)
                FCM_READ: begin
                    // sequences start here and in identifier read mode
                    if (wr32 && bus.addr == `FCM_UNLOCK_A1 && bus.wdata == `FCM_UNLOCK_D1)
                        mode_r <= FCM_C1;
                end
                FCM_C1: begin
                    if (wr32) begin
                        if (bus.addr == `FCM_UNLOCK_A2 && bus.wdata == `FCM_UNLOCK_D2)
                            mode_r <= FCM_C2;
                        else
                            mode_r <= FCM_READ;
                    end
                end
                FCM_C2: begin
                    // third write: decode command or finish software reset
                    if (wr32) begin
                        if (bus.addr != `FCM_CMD_A3 || is_f0) begin
                            mode_r <= FCM_READ;
                        end else if (bus.wdata == `FCM_CMD_PROG) begin
                            mode_r  <= FCM_PAGE;
                            op_r    <= FCM_OP_PROG;
                            words_r <= `FCM_PAGE_WORDS;
                        end else if (bus.wdata == `FCM_CMD_IDRD) begin
                            mode_r <= FCM_IDRD;
                        end else if (bus.wdata == `FCM_CMD_ERASE) begin
                            mode_r <= FCM_C3;
                        end else begin
                            mode_r <= FCM_READ;
                        end
                    end
                end
                FCM_C3: begin
                    if (wr32) begin
                        if (bus.addr == `FCM_UNLOCK_A1 && bus.wdata == `FCM_UNLOCK_D1)
                            mode_r <= FCM_E4;
                        else
                            mode_r <= FCM_READ;
                    end
                end
                FCM_E4: begin
                    if (wr32) begin
                        if (bus.addr == `FCM_UNLOCK_A2 && bus.wdata == `FCM_UNLOCK_D2)
                            mode_r <= FCM_E5;
                        else
                            mode_r <= FCM_READ;
                    end
                end
                FCM_E5: begin
                    // sixth write picks chip or block erase
                    if (wr32) begin
                        if (bus.addr == `FCM_CMD_A3 && bus.wdata == `FCM_CMD_CHIP) begin
                            sel_r <= ~protect_in;
                            op_r  <= FCM_OP_CHIP;
                            if (&protect_in) begin
                                mode_r <= FCM_READ;
                            end else begin
                                mode_r   <= FCM_BUSY;
                                tstart_r <= 1'b1;
                                tlen_r   <= ERASE_CYC;
                            end
                        end else if (bus.wdata == `FCM_CMD_BLOCK) begin
                            sel_r  <= blk_hit & ~protect_in;
                            op_r   <= FCM_OP_BLOCK;
                            mode_r <= FCM_E6;
                        end else begin
                            mode_r <= FCM_READ;
                        end
                    end
                end
                FCM_E6: begin
                    // protected target: nothing to erase, back to read
                    if (sel_r == '0) begin
                        mode_r <= FCM_READ;
                    end else begin
                        mode_r   <= FCM_BUSY;
                        tstart_r <= 1'b1;
                        tlen_r   <= ERASE_CYC;
                    end
                end
                FCM_IDRD: begin
                    // stays until a single F0 write or the first write of a new sequence
                    if (is_f0)
                        mode_r <= FCM_READ;
                    else if (wr32 && bus.addr == `FCM_UNLOCK_A1 && bus.wdata == `FCM_UNLOCK_D1)
                        mode_r <= FCM_C1;
                end
                FCM_PAGE: begin
                    // data words; software reset no longer honoured here
                    if (wr32) begin
                        if (words_r == `FCM_PAGE_WORDS)
                            prot_r <= |(blk_hit & protect_in);
                        words_r <= words_r - 8'h01;
                        if (words_r == 8'h01) begin
                            mode_r   <= FCM_BUSY;
                            tstart_r <= 1'b1;
                            tlen_r   <= PROG_CYC;
                        end
                    end
                end
                FCM_BUSY: begin
                    // writes ignored; only the timer, a failure or a hardware reset ends it
                    if (fail_in)
                        mode_r <= FCM_LOCK;
                    else if (tdone)
                        mode_r <= FCM_READ;
                end
                FCM_LOCK: begin
                    mode_r <= FCM_LOCK;
                end
                // unused state codes fall back to read mode
                default: begin
                    mode_r <= FCM_READ;
                end
            endcase
            // single-cycle read command from any idle or sequence mode
            if (is_f0 && !auto_mode && mode_r != FCM_C2)
                mode_r <= FCM_READ;
        end
    end

    // array write strobe, suppressed for protected pages
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in)
            array_wr_out <= 1'b0;
        else
            // first word judges the live decode, since prot_r may still hold the previous page
            array_wr_out <= (mode_r == FCM_PAGE) && wr32
                            && ((words_r == `FCM_PAGE_WORDS) ? !(|(blk_hit & protect_in)) : !prot_r);
    end

    // erase strobes and lock indicator
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            erase_out     <= 1'b0;
            erase_sel_out <= '0;
            lock_out      <= 1'b0;
        end else begin
            erase_out     <= (mode_r == FCM_BUSY) && (op_r != FCM_OP_PROG);
            erase_sel_out <= (mode_r == FCM_BUSY && op_r != FCM_OP_PROG) ? sel_r : '0;
            lock_out      <= (mode_r == FCM_LOCK);
        end
    end

    // read path: data in every non-automatic mode, including the reset vector
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            bus.rdata           <= '0;
            bus.rd_ok           <= 1'b0;
            bus.ready_busy_flag <= 1'b1;
        end else begin
            bus.rd_ok           <= bus.rd_valid && !auto_mode;
            bus.rdata           <= (bus.rd_valid && !auto_mode) ? array_data_in : '0;
            bus.ready_busy_flag <= !(auto_mode || tbusy);
        end
    end
endmodule

//--- fcm_host.sv
`timescale 1ns/1ps
`include "fcm_defs.svh"
// cpu-side end: issues 32-bit command writes one at a time, as the user side presents them
module fcm_host
    import fcm_pkg::*;
(
    // clock and reset
    input  wire logic mclk_in,
    input  wire logic reset_n_in,
    // user side
    input  wire logic               cmd_valid_in,  // one write to issue
    input  wire logic [`FCM_AW-1:0] cmd_addr_in,
    input  wire logic [`FCM_DW-1:0] cmd_data_in,
    input  wire logic               first_in,      // first write of a command
    input  wire logic               rd_req_in,     // array read request
    output logic                    cmd_ready_out, // write taken
    output logic                    rd_done_out,   // read answered
    output logic [`FCM_DW-1:0]      rd_data_out,
    output logic                    busy_seen_out, // ready flag low
    // bus side
    fcm_if.host       bus
);
    logic in_seq_r;  // inside a command sequence
    // issue writes one at a time; first write waits for ready flag
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            bus.wr_valid  <= 1'b0;
            bus.addr      <= '0;
            bus.wdata     <= '0;
            bus.word_size <= 1'b1;
            cmd_ready_out <= 1'b0;
            in_seq_r      <= 1'b0;
        end else begin
            bus.wr_valid  <= 1'b0;
            cmd_ready_out <= 1'b0;
            if (cmd_valid_in && !bus.wr_valid && (!first_in || bus.ready_busy_flag)) begin
                bus.wr_valid  <= 1'b1;
                bus.addr      <= cmd_addr_in;
                bus.wdata     <= cmd_data_in;
                bus.word_size <= 1'b1;
                cmd_ready_out <= 1'b1;
                in_seq_r      <= 1'b1;
            end else if (!cmd_valid_in) begin
                in_seq_r <= 1'b0;
            end
        end
    end
    // reads held off during a sequence to keep recognition clean
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            bus.rd_valid  <= 1'b0;
            rd_done_out   <= 1'b0;
            rd_data_out   <= '0;
            busy_seen_out <= 1'b0;
        end else begin
            bus.rd_valid  <= rd_req_in && !in_seq_r && !cmd_valid_in && !bus.rd_valid;
            rd_done_out   <= bus.rd_ok;
            rd_data_out   <= bus.rdata;
            busy_seen_out <= !bus.ready_busy_flag;
        end
    end
endmodule

//--- fcm_if.sv
`timescale 1ns/1ps
`include "fcm_defs.svh"
interface fcm_if;
    logic                wr_valid;   // one-cycle bus write
    logic [`FCM_AW-1:0]  addr;
    logic [`FCM_DW-1:0]  wdata;
    logic                word_size;  // high when the write is 32 bits wide
    logic                rd_valid;   // one-cycle array read or fetch
    logic [`FCM_DW-1:0]  rdata;
    logic                rd_ok;      // array data is valid this cycle
    logic                ready_busy_flag;
    modport dev  (input wr_valid, addr, wdata, word_size, rd_valid,
                  output rdata, rd_ok, ready_busy_flag);
    modport host (output wr_valid, addr, wdata, word_size, rd_valid,
                  input rdata, rd_ok, ready_busy_flag);
endinterface

//--- fcm_pkg.sv
package fcm_pkg;
    // controller mode
    typedef enum logic [3:0] {
        FCM_READ, FCM_C1, FCM_C2, FCM_C3, FCM_E4, FCM_E5, FCM_E6,
        FCM_IDRD, FCM_PAGE, FCM_BUSY, FCM_LOCK
    } fcm_mode_t;
    // operation kind started by the sequencer
    typedef enum logic [1:0] {
        FCM_OP_PROG, FCM_OP_CHIP, FCM_OP_BLOCK
    } fcm_op_t;
endpackage

//--- fcm_timer.sv
`timescale 1ns/1ps
`include "fcm_defs.svh"
// counts down an operation; done pulses for one cycle at the end
module fcm_timer #(
    parameter int CW = 16
) (
    input  wire logic          mclk_in,
    input  wire logic          reset_n_in,
    input  wire logic          start_in,
    input  wire logic [CW-1:0] len_in,
    output logic               busy_out,
    output logic               done_out
);
    logic [CW-1:0] cnt_r;  // cycles left
    initial begin
        if (CW < 2) $error("fcm_timer: CW too small");
    end
    // countdown, restartable only when idle
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            cnt_r    <= '0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (start_in && !busy_out) begin
                cnt_r    <= len_in;
                busy_out <= 1'b1;
            end else if (busy_out) begin
                if (cnt_r <= CW'(1)) begin
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - CW'(1);
                end
            end
        end
    end
endmodule

//--- flash_command_mode_control_tb.sv
`timescale 1ns/1ps
`include "fcm_defs.svh"
// both ends joined; the bench plays the cpu user side and the array side
module flash_command_mode_control_tb
    import fcm_pkg::*;
;
    // user side of the host end
    logic        mclk_in       = 1'b0;
    logic        reset_n_in    = 1'b0;
    logic        cmd_valid_in  = 1'b0;
    logic [31:0] cmd_addr_in   = 32'h0000_0000;
    logic [31:0] cmd_data_in   = 32'h0000_0000;
    logic        first_in      = 1'b0;
    logic        rd_req_in     = 1'b0;
    logic        cmd_ready_out;
    logic        rd_done_out;
    logic [31:0] rd_data_out;
    logic        busy_seen_out;
    // array side of the device end
    logic [7:0]  protect_in    = 8'h00;
    logic [31:0] array_data_in = 32'h0000_0000;
    logic        fail_in       = 1'b0;
    logic        array_wr_out;
    logic        erase_out;
    logic [7:0]  erase_sel_out;
    logic        lock_out;
    // bookkeeping
    int          err_count     = 0;
    int          n_checks      = 0;
    int          n_wr          = 0;
    int          cyc           = 0;
    logic        er_seen       = 1'b0;
    logic [7:0]  sel_cap       = 8'h00;

    always #25 mclk_in = ~mclk_in;

    fcm_if link ();
    // short op counts keep the run brief
    fcm_device #(.BLOCKS(8), .PROG_CYC(16'h0010), .ERASE_CYC(16'h0040)) fcm_device_i (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in), .bus(link), .protect_in(protect_in),
        .array_data_in(array_data_in), .fail_in(fail_in), .array_wr_out(array_wr_out),
        .erase_out(erase_out), .erase_sel_out(erase_sel_out), .lock_out(lock_out));
    fcm_host fcm_host_i (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in), .cmd_valid_in(cmd_valid_in),
        .cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in), .first_in(first_in),
        .rd_req_in(rd_req_in), .cmd_ready_out(cmd_ready_out), .rd_done_out(rd_done_out),
        .rd_data_out(rd_data_out), .busy_seen_out(busy_seen_out), .bus(link));
    fcm_checker fcm_checker_i (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in), .wr_valid(link.wr_valid),
        .word_size(link.word_size), .rd_valid(link.rd_valid), .rd_ok(link.rd_ok),
        .ready_busy_flag(link.ready_busy_flag), .lock_out(lock_out), .erase_out(erase_out),
        .array_wr_out(array_wr_out));

    // count page words and catch erase selections; also the hang guard
    always @(posedge mclk_in) begin
        cyc = cyc + 1;
        if (array_wr_out === 1'b1) begin
            n_wr = n_wr + 1;
        end
        if (erase_out === 1'b1) begin
            er_seen = 1'b1;
            sel_cap = erase_sel_out;
        end
        if (cyc == 30000) begin
            $display("ERROR at %0t: run timed out", $time);
            err_count = err_count + 1;
            finish_test();
        end
    end

    // verdict and end of run
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        n_checks = n_checks + 1;
        if (ok !== 1'b1) begin
            err_count = err_count + 1;
            $display("ERROR at %0t: %s", $time, msg);
        end
    endtask

    // hold the request until the host says it went out
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic f);
        int i;
        @(negedge mclk_in);
        cmd_valid_in = 1'b1;
        cmd_addr_in = a;
        cmd_data_in = d;
        first_in = f;
        for (i = 0; i < 64 && cmd_ready_out !== 1'b1; i++) begin
            @(negedge mclk_in);
        end
        chk(cmd_ready_out === 1'b1, "write not taken");
        cmd_valid_in = 1'b0;
    endtask

    task automatic rd(input int n, output logic got);
        int i;
        @(negedge mclk_in);
        rd_req_in = 1'b1;
        got = 1'b0;
        for (i = 0; i < n && !got; i++) begin
            @(negedge mclk_in);
            got = (rd_done_out === 1'b1);
        end
        rd_req_in = 1'b0;
    endtask

    task automatic wait_rdy(input int n);
        int i;
        for (i = 0; i < n && link.ready_busy_flag !== 1'b1; i++) begin
            @(negedge mclk_in);
        end
    endtask

    task automatic do_reset(input int n);
        @(negedge mclk_in);
        reset_n_in = 1'b0;
        repeat (n) @(negedge mclk_in);
        reset_n_in = 1'b1;
    endtask

    task automatic cmd3(input logic [31:0] d);
        wr(`FCM_UNLOCK_A1, `FCM_UNLOCK_D1, 1'b1);
        wr(`FCM_UNLOCK_A2, `FCM_UNLOCK_D2, 1'b0);
        wr(`FCM_CMD_A3, d, 1'b0);
    endtask

    task automatic erase6(input logic [31:0] a, input logic [31:0] d);
        cmd3(`FCM_CMD_ERASE);
        wr(`FCM_UNLOCK_A1, `FCM_UNLOCK_D1, 1'b0);
        wr(`FCM_UNLOCK_A2, `FCM_UNLOCK_D2, 1'b0);
        wr(a, d, 1'b0);
    endtask

    // ready after reset, and the first read is served
    task automatic t_basic();
        logic got;
        chk(link.ready_busy_flag === 1'b1 && lock_out === 1'b0, "not ready after reset");
        array_data_in = 32'h5a5a_c3c3;
        rd(8, got);
        chk(got === 1'b1 && rd_data_out === 32'h5a5a_c3c3, "read data wrong");
    endtask

    // broken or cancelled sequences must not leave a half command armed
    task automatic t_abort();
        int k;
        int base;
        logic got;
        for (k = 0; k < 4; k++) begin
            base = n_wr;
            case (k)
                0: cmd3(`FCM_READ_DATA);
                1: begin
                    wr(`FCM_UNLOCK_A1, `FCM_UNLOCK_D1, 1'b1);
                    wr(`FCM_UNLOCK_A2, 32'h0000_0066, 1'b0);
                end
                2: begin
                    // identifier read keeps serving reads until a single F0 write
                    cmd3(`FCM_CMD_IDRD);
                    rd(8, got);
                    chk(got === 1'b1 && link.ready_busy_flag === 1'b1, "identifier read mode refused");
                    wr(32'h0000_0100, `FCM_READ_DATA, 1'b0);
                end
                default: begin
                    wr(`FCM_UNLOCK_A1, `FCM_UNLOCK_D1, 1'b1);
                    wr(32'h0001_2340, `FCM_READ_DATA, 1'b0);
                    wr(`FCM_UNLOCK_A2, `FCM_UNLOCK_D2, 1'b0);
                end
            endcase
            wr(`FCM_CMD_A3, `FCM_CMD_PROG, 1'b0);
            repeat (4) @(negedge mclk_in);
            chk(link.ready_busy_flag === 1'b1 && n_wr == base, "aborted sequence still ran");
        end
    endtask

    // one full page, protected or not
    task automatic t_prog(input logic [7:0] prot, input logic [31:0] page, input int exp);
        int i;
        int base;
        protect_in = prot;
        base = n_wr;
        cmd3(`FCM_CMD_PROG);
        // mode at +1, flag at +2, host's copy of it at +3
        repeat (3) @(negedge mclk_in);
        chk(link.ready_busy_flag === 1'b0 && busy_seen_out === 1'b1, "not busy in program");
        for (i = 0; i < 128; i++) begin
            wr(page + 32'(i * 4), ~32'(i), 1'b0);
        end
        wait_rdy(400);
        chk(link.ready_busy_flag === 1'b1, "program did not end");
        chk(n_wr - base == exp, "page word count wrong");
    endtask

    // erase with a given protection; exp is the expected block selection
    task automatic t_erase(input logic [7:0] prot, input logic [31:0] a, input logic [31:0] d,
                           input logic [7:0] exp);
        protect_in = prot;
        er_seen = 1'b0;
        sel_cap = 8'h00;
        erase6(a, d);
        // block erase spends one extra cycle before the flag drops
        repeat (3) @(negedge mclk_in);
        wait_rdy(400);
        chk({er_seen, sel_cap} === {exp != 8'h00, exp}, "erase selection wrong");
    endtask

    // no data, no commands, no software exit while erasing or locked
    task automatic t_busy();
        logic got;
        protect_in = 8'h00;
        erase6(`FCM_CMD_A3, `FCM_CMD_CHIP);
        repeat (3) @(negedge mclk_in);
        rd(6, got);
        chk(got === 1'b0, "read served while busy");
        wr(32'h0000_0000, `FCM_READ_DATA, 1'b0);
        chk(link.ready_busy_flag === 1'b0 && erase_out === 1'b1, "command taken while busy");
        fail_in = 1'b1;
        repeat (3) @(negedge mclk_in);
        fail_in = 1'b0;
        wr(`FCM_UNLOCK_A1, `FCM_UNLOCK_D1, 1'b0);
        wr(`FCM_UNLOCK_A2, `FCM_UNLOCK_D2, 1'b0);
        wr(`FCM_CMD_A3, `FCM_READ_DATA, 1'b0);
        chk(lock_out === 1'b1 && link.ready_busy_flag === 1'b0, "lock left by software");
        do_reset(2);
        chk(lock_out === 1'b0 && link.ready_busy_flag === 1'b1, "lock kept after reset");
        erase6(`FCM_CMD_A3, `FCM_CMD_CHIP);
        repeat (3) @(negedge mclk_in);
        do_reset(2);
        chk(erase_out === 1'b0 && link.ready_busy_flag === 1'b1, "erase kept after reset");
        t_basic();
    endtask

    // main sequence
    initial begin
        do_reset(12);
        t_basic();
        t_abort();
        t_prog(8'h00, 32'h0002_0000, 128);
        t_prog(8'h04, 32'h0002_0200, 0);
        t_erase(8'h00, `FCM_CMD_A3, `FCM_CMD_CHIP, 8'hff);
        t_erase(8'hff, `FCM_CMD_A3, `FCM_CMD_CHIP, 8'h00);
        t_erase(8'h01, 32'h0003_0000, `FCM_CMD_BLOCK, 8'h08);
        t_erase(8'h08, 32'h0003_0000, `FCM_CMD_BLOCK, 8'h00);
        t_busy();
        finish_test();
    end
endmodule
